// ===== rtl/boot_cfg_pkg.sv
// Package: register map, fuse and lock field layout, reset values.
// Assumes byte-wide fuse storage mirrored into 32-bit AXI4-Lite words.
package boot_cfg_pkg;

  // ==========================================================
  // Bus geometry
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_FUSE_EXT = 8'h00;
  localparam logic [7:0] OFS_FUSE_HIGH = 8'h04;
  localparam logic [7:0] OFS_FUSE_LOW = 8'h08;
  localparam logic [7:0] OFS_LOCK = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_ACTIVE = 8'h14;
  localparam logic [7:0] OFS_SIGNATURE = 8'h18;
  localparam logic [7:0] OFS_OSC_CALIBRATION_REG = 8'h1c;

  // ==========================================================
  // Reset values (0 = programmed, 1 = unprogrammed)
  localparam logic [7:0] FUSE_EXT_RST = 8'hff;
  localparam logic [7:0] FUSE_HIGH_RST = 8'h99;
  localparam logic [7:0] FUSE_LOW_RST = 8'h62;
  localparam logic [7:0] LOCK_RST = 8'hff;
  localparam logic [7:0] EXT_UNUSED_MASK = 8'hf8;
  localparam logic [7:0] LOCK_UNUSED_MASK = 8'hc0;

  // ==========================================================
  // Field positions
  localparam int FH_DEBUG = 7;
  localparam int FH_SCAN = 6;
  localparam int FH_SERIAL = 5;
  localparam int FH_WDOG = 4;
  localparam int FH_PRESERVE = 3;
  localparam int FH_BOOT_LO = 1;
  localparam int FH_RESET_VEC = 0;
  localparam int FL_DIV8 = 7;
  localparam int FL_CLOCK_OUTPUT_FUSE = 6;
  localparam int FL_SUT_LO = 4;
  localparam int FL_CKSEL_LO = 0;
  localparam int LK_READ = 5;
  localparam int LK_WRITE = 4;
  localparam int LK_MEM_B = 1;
  localparam int LK_MEM_A = 0;
  localparam int CTRL_PROG = 0;
  localparam int CTRL_SERIAL = 1;
  localparam int CTRL_ERASE = 2;

endpackage

// ===== rtl/lock_gate.sv
// Boot-section access gate: decodes the two boot lock bits per request.
// Assumes requests and section flags come from logic on the same clock.
`timescale 1ns/1ps
module lock_gate (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Stored lock bits (0 = programmed)
  input wire logic boot_read_lock,
  input wire logic boot_write_lock,
  // Core requests
  input wire logic store_req,
  input wire logic load_req,
  input wire logic target_in_boot,
  input wire logic exec_in_boot,
  input wire logic vectors_in_app,
  // Verdicts
  output logic store_allow,
  output logic load_allow,
  output logic irq_allow
);

  // ==========================================================
  // Verdicts, one cycle after the request
  always_ff @(posedge clk) begin
    if (reset) begin
      store_allow <= 1'b0;
      load_allow <= 1'b0;
      irq_allow <= 1'b0;
    end else if (ce) begin
      store_allow <= store_req && !(target_in_boot && !boot_write_lock); // R1 R2 R22
      load_allow <= load_req && !(target_in_boot && !exec_in_boot && !boot_read_lock); // R3 R22
      irq_allow <= !(!boot_read_lock && vectors_in_app && exec_in_boot); // R4
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence seq_open;
    ce && boot_read_lock && boot_write_lock;
  endsequence

  AST_OPEN_ACCESS: assert property ( // R1
    seq_open ##0 (store_req && load_req) |=> store_allow && load_allow && irq_allow)
    else $error("unlocked boot section refused an access");
  AST_STORE_BLOCK: assert property ( // R2
    ce && store_req && target_in_boot && !boot_write_lock |=> !store_allow)
    else $error("store into write-locked boot section allowed");
  AST_LOAD_BLOCK: assert property ( // R3
    ce && target_in_boot && !exec_in_boot && !boot_read_lock |=> !load_allow)
    else $error("cross-section load from read-locked boot section allowed");
  AST_IRQ_MASK: assert property ( // R4
    ce && !boot_read_lock && vectors_in_app |=> irq_allow == !$past(exec_in_boot))
    else $error("interrupt gating wrong while executing in boot section");

endmodule

// ===== rtl/boot_config_top.sv
// Fuse, lock, signature and calibration store behind an AXI4-Lite slave.
// Assumes AXI masters on clk; core access requests on the same clock.
//
// Contract
// R1 - Both boot lock bits unprogrammed: boot section stores and loads unrestricted.
// R2 - Boot write lock programmed: every store into boot section is blocked.
// R3 - Boot read lock programmed: application-code loads from boot section blocked.
// R4 - Read lock programmed, vectors in application: interrupts off while in boot.
// R5 - Programmer should set fuses and boot locks before memory locks.
// R6 - Fuses read 0 when programmed, 1 when unprogrammed; unused read 1.
// R7 - Extended byte: bits 7..3 unused, bits 2..0 brown-out level, default 1.
// R8 - High byte 7..5: debug, scan port, serial programming enables.
// R9 - High byte 4..0: watchdog on, eeprom preserve, boot size, reset vector.
// R10 - Low byte: divide by 8, clock out, start-up time, clock source.
// R11 - Default clock source is internal RC; clock-out fuse drives clock pin.
// R12 - Debug fuse programmed keeps clock system running in all sleep modes.
// R13 - Serial-programming fuse not readable or writable in serial mode.
// R14 - Chip erase leaves all fuse values unchanged.
// R15 - Memory lock A programmed: further fuse changes refused.
// R16 - Fuses latched on entering programming mode; changes apply after leaving.
// R17 - Eeprom-preserve fuse takes effect as soon as it is programmed.
// R18 - Fuses latched at power-up in normal mode and used from that copy.
// R19 - Three signature bytes at 0..2, always readable even when locked.
// R20 - Calibration byte copied into oscillator calibration register during reset.
// R21 - Lock bits return to 1 only through chip erase.
// R22 - Two boot lock bits decoded independently for stores and reads.
`timescale 1ns/1ps
module boot_config_top import boot_cfg_pkg::*; #(
  parameter logic [7:0] SIG_BYTE0 = 8'h5a, // arbitrary identity value
  parameter logic [7:0] SIG_BYTE1 = 8'h3c, // arbitrary identity value
  parameter logic [7:0] SIG_BYTE2 = 8'h17, // arbitrary identity value
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [AXI_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [AXI_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Core access requests
  input wire logic store_req,
  input wire logic load_req,
  input wire logic target_in_boot,
  input wire logic exec_in_boot,
  input wire logic vectors_in_app,
  // Access verdicts
  output logic store_allow,
  output logic load_allow,
  output logic irq_allow,
  // Active configuration, eeprom preserve from stored fuse (fuse polarity, 0 = programmed)
  output logic [2:0] brownout_level,
  output logic debug_enable_fuse,
  output logic scan_port_enable_fuse,
  output logic serial_prog_enable_fuse,
  output logic watchdog_forced_on,
  output logic eeprom_preserve_fuse,
  output logic [1:0] boot_size,
  output logic reset_vector_select,
  output logic clock_div_eight_fuse,
  output logic [1:0] startup_time,
  output logic [3:0] clock_source,
  // Derived clock controls
  output logic clock_keep_in_sleep,
  output logic clock_output_pin_oe,
  output logic [7:0] osc_calibration_reg
);

  // ==========================================================
  // Storage
  logic [7:0] fuse_ext;
  logic [7:0] fuse_high;
  logic [7:0] fuse_low;
  logic [7:0] lock;
  logic [7:0] act_ext;
  logic [7:0] act_high;
  logic [7:0] act_low;
  logic prog_mode;
  logic serial_mode;
  logic prog_q;
  logic powerup_pending;
  logic [AXI_ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;

  // ==========================================================
  // Decode helpers
  function automatic logic reg_mapped(input logic [AXI_ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a <= OFS_OSC_CALIBRATION_REG);
  endfunction

  function automatic logic is_fuse(input logic [AXI_ADDR_W-1:0] a);
    return (a == OFS_FUSE_EXT) || (a == OFS_FUSE_HIGH) || (a == OFS_FUSE_LOW);
  endfunction

  logic wr_exec;
  logic fuse_wr_ok;
  logic wr_err;
  logic erase;
  logic latch_now;

  assign wr_exec = ce && !awready && !wready && !bvalid;
  assign fuse_wr_ok = prog_mode && lock[LK_MEM_A]; // R15
  assign erase = wr_exec && w_lane0 && (aw_addr == OFS_CTRL) && prog_mode && w_byte[CTRL_ERASE];
  assign latch_now = powerup_pending || (prog_mode != prog_q); // R16 R18

  always_comb begin
    wr_err = 1'b0;
    if (!reg_mapped(aw_addr)) begin
      wr_err = 1'b1;
    end else if (is_fuse(aw_addr)) begin
      wr_err = !fuse_wr_ok;
    end else if (aw_addr == OFS_LOCK) begin
      wr_err = !prog_mode;
    end else if ((aw_addr == OFS_ACTIVE) || (aw_addr == OFS_SIGNATURE)) begin
      wr_err = 1'b1;
    end
  end

  // ==========================================================
  // Write channels, taken in either order
  always_ff @(posedge clk) begin
    if (reset) begin
      awready <= 1'b1;
      aw_addr <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_addr <= awaddr;
      end else if (bvalid && bready) begin
        awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wready <= 1'b1;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (ce) begin
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_byte <= wdata[7:0];
        w_lane0 <= wstrb[0];
      end else if (bvalid && bready) begin
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wr_exec) begin
        bvalid <= 1'b1;
        bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Non-volatile fuse bytes, untouched by chip erase
  always_ff @(posedge clk) begin
    if (reset) begin
      fuse_ext <= FUSE_EXT_RST;
      fuse_high <= FUSE_HIGH_RST;
      fuse_low <= FUSE_LOW_RST;
    end else if (wr_exec && w_lane0 && fuse_wr_ok) begin // R14 R15
      case (aw_addr)
        OFS_FUSE_EXT: fuse_ext <= w_byte | EXT_UNUSED_MASK; // R6 R7
        OFS_FUSE_HIGH: begin
          fuse_high <= w_byte; // R8 R9
          if (serial_mode) begin
            fuse_high[FH_SERIAL] <= fuse_high[FH_SERIAL]; // R13
          end
        end
        OFS_FUSE_LOW: fuse_low <= w_byte; // R10
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Lock byte: writes only program bits, erase restores
  always_ff @(posedge clk) begin
    if (reset) begin
      lock <= LOCK_RST;
    end else if (erase) begin
      lock <= LOCK_RST; // R21
    end else if (wr_exec && w_lane0 && prog_mode && (aw_addr == OFS_LOCK)) begin
      lock <= lock & (w_byte | LOCK_UNUSED_MASK); // R21
    end
  end

  // ==========================================================
  // Mode control
  always_ff @(posedge clk) begin
    if (reset) begin
      prog_mode <= 1'b0;
      serial_mode <= 1'b0;
    end else if (wr_exec && w_lane0 && (aw_addr == OFS_CTRL)) begin
      prog_mode <= w_byte[CTRL_PROG];
      serial_mode <= w_byte[CTRL_SERIAL];
    end
  end

  // ==========================================================
  // Active copy, latched at power-up and programming entry/exit
  always_ff @(posedge clk) begin
    if (reset) begin
      prog_q <= 1'b0;
      powerup_pending <= 1'b1;
      act_ext <= FUSE_EXT_RST;
      act_high <= FUSE_HIGH_RST;
      act_low <= FUSE_LOW_RST;
    end else if (ce) begin
      prog_q <= prog_mode;
      powerup_pending <= 1'b0;
      if (latch_now) begin
        act_ext <= fuse_ext; // R16 R18
        act_high <= fuse_high;
        act_low <= fuse_low;
      end
    end
  end

  assign brownout_level = act_ext[2:0]; // R7
  assign debug_enable_fuse = act_high[FH_DEBUG]; // R8
  assign scan_port_enable_fuse = act_high[FH_SCAN];
  assign serial_prog_enable_fuse = act_high[FH_SERIAL];
  assign watchdog_forced_on = act_high[FH_WDOG]; // R9
  assign eeprom_preserve_fuse = fuse_high[FH_PRESERVE]; // R17
  assign boot_size = act_high[FH_BOOT_LO +: 2];
  assign reset_vector_select = act_high[FH_RESET_VEC];
  assign clock_div_eight_fuse = act_low[FL_DIV8]; // R10
  assign startup_time = act_low[FL_SUT_LO +: 2];
  assign clock_source = act_low[FL_CKSEL_LO +: 4]; // R11

  // ==========================================================
  // Clock-system controls from active fuses
  always_ff @(posedge clk) begin
    if (reset) begin
      clock_keep_in_sleep <= 1'b0;
      clock_output_pin_oe <= 1'b0;
    end else if (ce) begin
      clock_keep_in_sleep <= !act_high[FH_DEBUG]; // R12
      clock_output_pin_oe <= !act_low[FL_CLOCK_OUTPUT_FUSE]; // R11
    end
  end

  // ==========================================================
  // Oscillator calibration, reloaded while reset is held
  always_ff @(posedge clk) begin
    if (reset) begin
      osc_calibration_reg <= CAL_BYTE; // R20
    end else if (wr_exec && w_lane0 && (aw_addr == OFS_OSC_CALIBRATION_REG)) begin
      osc_calibration_reg <= w_byte;
    end
  end

  // ==========================================================
  // Read channel
  logic [AXI_DATA_W-1:0] rd_word;
  logic [7:0] high_view;

  always_comb begin
    high_view = fuse_high;
    if (serial_mode) begin
      high_view[FH_SERIAL] = 1'b1; // R13
    end
    rd_word = '0;
    case (araddr)
      OFS_FUSE_EXT: rd_word[7:0] = fuse_ext | EXT_UNUSED_MASK; // R6 R7
      OFS_FUSE_HIGH: rd_word[7:0] = high_view;
      OFS_FUSE_LOW: rd_word[7:0] = fuse_low;
      OFS_LOCK: rd_word[7:0] = lock | LOCK_UNUSED_MASK;
      OFS_CTRL: rd_word[2:0] = {1'b0, serial_mode, prog_mode};
      OFS_ACTIVE: begin
        rd_word[23:0] = {act_ext, act_high, act_low};
        rd_word[8 + FH_PRESERVE] = fuse_high[FH_PRESERVE]; // R17
      end
      OFS_SIGNATURE: rd_word = {CAL_BYTE, SIG_BYTE2, SIG_BYTE1, SIG_BYTE0}; // R19 R20
      OFS_OSC_CALIBRATION_REG: rd_word[7:0] = osc_calibration_reg;
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= reg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Boot-section gate
  lock_gate u_gate (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .boot_read_lock(lock[LK_READ]), // R22
    .boot_write_lock(lock[LK_WRITE]),
    .store_req(store_req),
    .load_req(load_req),
    .target_in_boot(target_in_boot),
    .exec_in_boot(exec_in_boot),
    .vectors_in_app(vectors_in_app),
    .store_allow(store_allow),
    .load_allow(load_allow),
    .irq_allow(irq_allow)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence seq_fuse_write;
    wr_exec && w_lane0 && is_fuse(aw_addr);
  endsequence

  sequence seq_prog_enter;
    ce && prog_mode && !prog_q;
  endsequence

  sequence seq_sig_read;
    ce && arvalid && arready && (araddr == OFS_SIGNATURE);
  endsequence

  AST_EXT_UNUSED_ONES: assert property ( // R7
    fuse_ext[7:3] == 5'h1f)
    else $error("unused extended fuse bits not at one");
  AST_FUSE_LOCKED: assert property ( // R15
    seq_fuse_write ##0 !lock[LK_MEM_A] |=> $stable(fuse_ext) && $stable(fuse_high)
      && $stable(fuse_low) && bresp == RESP_SLVERR)
    else $error("fuse changed while memory lock A programmed");
  AST_ERASE_KEEPS_FUSES: assert property ( // R14
    erase |=> $stable(fuse_ext) && $stable(fuse_high) && $stable(fuse_low) && lock == LOCK_RST)
    else $error("chip erase disturbed fuses or left locks set");
  AST_LOCK_ONLY_ERASE: assert property ( // R21
    !erase |=> (lock & ~$past(lock)) == 8'h00)
    else $error("lock bit returned to one without chip erase");
  AST_SERIAL_HIDDEN: assert property ( // R13
    seq_fuse_write ##0 serial_mode && aw_addr == OFS_FUSE_HIGH |=> $stable(fuse_high[FH_SERIAL]))
    else $error("serial programming fuse changed in serial mode");
  AST_ENTRY_LATCH: assert property ( // R16
    seq_prog_enter |=> act_low == $past(fuse_low) && act_high == $past(fuse_high))
    else $error("fuses not latched on programming entry");
  AST_PROG_HOLD: assert property ( // R16
    ce && prog_mode && prog_q && !powerup_pending |=> $stable(act_low) && $stable(act_ext))
    else $error("active fuses changed inside programming mode");
  AST_PRESERVE_NOW: assert property ( // R17
    seq_fuse_write ##0 fuse_wr_ok && aw_addr == OFS_FUSE_HIGH
      |=> eeprom_preserve_fuse == $past(w_byte[FH_PRESERVE]))
    else $error("eeprom preserve fuse did not act at once");
  AST_POWERUP_LATCH: assert property ( // R18
    ce && powerup_pending |=> act_high == $past(fuse_high) && !powerup_pending)
    else $error("fuses not latched at power-up");
  AST_SIG_READ: assert property ( // R19
    seq_sig_read |=> rvalid && rresp == RESP_OKAY
      && rdata == {CAL_BYTE, SIG_BYTE2, SIG_BYTE1, SIG_BYTE0})
    else $error("signature word wrong");
  AST_CAL_RESET: assert property ( // R20
    $past(reset) |-> osc_calibration_reg == CAL_BYTE)
    else $error("calibration byte not loaded at reset");

endmodule

// ===== testbench/core_access_model.sv
// Core-side model: presents self-program and load requests to the gate.
// Assumes the caller invokes drive right after a rising clock edge.
`timescale 1ns/1ps
module core_access_model (
  // Clock
  input wire logic clk,
  // Requests toward the gate
  output logic store_req,
  output logic load_req,
  output logic target_in_boot,
  output logic exec_in_boot,
  output logic vectors_in_app
);
  initial begin
    {store_req, load_req, target_in_boot, exec_in_boot, vectors_in_app} = 5'h00;
  end

  // Order: store, load, target in boot, exec in boot, vectors in app
  task automatic drive(input logic [4:0] v);
    {store_req, load_req, target_in_boot, exec_in_boot, vectors_in_app} <= v;
  endtask
endmodule

// ===== testbench/tb_boot_config_top.sv
// Self-checking bench: AXI4-Lite register tasks and core gate requests.
// Assumes boot_config_top defaults and the core model on the same clock.
`timescale 1ns/1ps
module tb_boot_config_top import boot_cfg_pkg::*; ;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic st_req, ld_req, tgt_boot, ex_boot, vec_app, st_ok, ld_ok, irq_ok;
  logic [2:0] bod;
  logic dbg, scan, ser, wdog, pres, rvec, div8, keep, ckoe;
  logic [1:0] bsz, sut;
  logic [3:0] cksrc;
  logic [7:0] osc;
  logic [17:0] cfg;
  int num_errors = 0;
  int samples_checked = 0;
  assign cfg = {bod, dbg, scan, ser, wdog, pres, bsz, rvec, div8, sut, cksrc};

  always #12.5 clk = ~clk;

  core_access_model u_core_access_model (.clk(clk), .store_req(st_req), .load_req(ld_req),
    .target_in_boot(tgt_boot), .exec_in_boot(ex_boot), .vectors_in_app(vec_app));

  boot_config_top u_boot_config_top (.clk(clk), .reset(reset), .ce(1'b1),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .store_req(st_req), .load_req(ld_req), .target_in_boot(tgt_boot),
    .exec_in_boot(ex_boot), .vectors_in_app(vec_app),
    .store_allow(st_ok), .load_allow(ld_ok), .irq_allow(irq_ok),
    .brownout_level(bod), .debug_enable_fuse(dbg), .scan_port_enable_fuse(scan),
    .serial_prog_enable_fuse(ser), .watchdog_forced_on(wdog), .eeprom_preserve_fuse(pres),
    .boot_size(bsz), .reset_vector_select(rvec), .clock_div_eight_fuse(div8),
    .startup_time(sut), .clock_source(cksrc), .clock_keep_in_sleep(keep),
    .clock_output_pin_oe(ckoe), .osc_calibration_reg(osc));

  // ==========================================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ah, wh;
    ah = 1'b0;
    wh = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ah && wh)) begin
      @(posedge clk);
      if (!ah && awready === 1'b1) begin
        ah = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wh && wready === 1'b1) begin
        wh = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    chk("rdata", ed, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  // One request, verdict checked just after the edge that samples it
  task automatic gate_case(input logic [4:0] v, input logic [2:0] e);
    @(posedge clk);
    u_core_access_model.drive(v);
    @(posedge clk);
    #1;
    chk("verdicts", {29'h0, e}, {29'h0, st_ok, ld_ok, irq_ok});
  endtask

  // App code to boot, then boot code with vectors in app
  task automatic gate(input logic [7:0] lk);
    gate_case(5'b11101, {lk[LK_WRITE], lk[LK_READ], 1'b1});
    gate_case(5'b11111, {lk[LK_WRITE], 1'b1, lk[LK_READ]});
  endtask

  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #(25.0 * 5000);
    num_errors++;
    stop_test();
  end

  // ==========================================================
  // Tests
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  logic [31:0] rv [8] = '{32'hff, 32'h99, 32'h62, 32'hff, 32'h0, 32'h00ff9962,
    32'h80173c5a, 32'h80};
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("cfg", {3'h7, 5'h13, 2'h0, 1'h1, 1'h0, 2'h2, 4'h2}, cfg);
    chk("clock", 2'b00, {keep, ckoe});
    chk("osc", 8'h80, osc);
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i], RESP_OKAY);
    wr(OFS_FUSE_LOW, 8'h22, RESP_SLVERR);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(OFS_SIGNATURE, 8'h00, RESP_SLVERR);
    wr(OFS_CTRL, 8'h01, RESP_OKAY);
    wr(OFS_FUSE_EXT, 8'h00, RESP_OKAY);
    rd(OFS_FUSE_EXT, 32'hf8, RESP_OKAY);
    wr(OFS_FUSE_HIGH, 8'h11, RESP_OKAY);
    wr(OFS_FUSE_LOW, 8'h22, RESP_OKAY);
    #1;
    chk("preserve", 1'b0, pres);
    chk("cfg", {3'h7, 5'h12, 2'h0, 1'h1, 1'h0, 2'h2, 4'h2}, cfg);
    wr(OFS_CTRL, 8'h00, RESP_OKAY);
    repeat (3) @(posedge clk);
    #1;
    chk("cfg", {3'h0, 5'h02, 2'h0, 1'h1, 1'h0, 2'h2, 4'h2}, cfg);
    chk("clock", 2'b11, {keep, ckoe});
    rd(OFS_ACTIVE, 32'h00f81122, RESP_OKAY);
    wr(OFS_CTRL, 8'h03, RESP_OKAY);
    rd(OFS_FUSE_HIGH, 32'h31, RESP_OKAY);
    wr(OFS_FUSE_HIGH, 8'h39, RESP_OKAY);
    wr(OFS_CTRL, 8'h01, RESP_OKAY);
    rd(OFS_FUSE_HIGH, 32'h19, RESP_OKAY);
    gate(8'hff);
    wr(OFS_LOCK, 8'hef, RESP_OKAY);
    gate(8'hef);
    wr(OFS_LOCK, 8'hcf, RESP_OKAY);
    gate(8'hcf);
    wr(OFS_LOCK, 8'hff, RESP_OKAY);
    rd(OFS_LOCK, 32'hcf, RESP_OKAY);
    wr(OFS_CTRL, 8'h05, RESP_OKAY);
    rd(OFS_LOCK, 32'hff, RESP_OKAY);
    wr(OFS_LOCK, 8'hdf, RESP_OKAY);
    gate(8'hdf);
    wr(OFS_LOCK, 8'hfe, RESP_OKAY);
    wr(OFS_FUSE_HIGH, 8'h99, RESP_SLVERR);
    rd(OFS_FUSE_HIGH, 32'h19, RESP_OKAY);
    wr(OFS_CTRL, 8'h05, RESP_OKAY);
    rd(OFS_FUSE_HIGH, 32'h19, RESP_OKAY);
    rd(OFS_FUSE_LOW, 32'h22, RESP_OKAY);
    rd(OFS_LOCK, 32'hff, RESP_OKAY);
    wr(OFS_OSC_CALIBRATION_REG, 8'h44, RESP_OKAY);
    #1;
    chk("osc", 8'h44, osc);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk("osc", 8'h80, osc);
    rd(OFS_FUSE_LOW, 32'h62, RESP_OKAY);
    stop_test();
  end
endmodule
